// File: hw/branch_params.svh
// Constants of the flow-control execution block: offsets, fields, codes.
// Assumes the includer uses byte addresses on an AXI4-Lite bus with 8-bit addresses.
// Operation
// - Relative target is instruction address plus displacement
// - Absolute forms use immediate as target
// - Link writes following address into return register
// - Selector picks tested flag; options decide use
// - To-return form jumps to return register
// - Return target read before link overwrites it
// - To-count form jumps to count register
// - To-count with decrement option is invalid
// - Flag logic or field copy with link invalid
// - AND, OR, XOR combine two flag bits
// - NAND, NOR, equivalence store inverted result
// - Complement forms invert only second source
// - Field copy moves one field, others untouched
// - Options select count test, condition, or always
// - Register targets have two low bits cleared
// - Link updates whether or not branch taken
`ifndef BRANCH_PARAMS_SVH
`define BRANCH_PARAMS_SVH

`define OFS_INSTR_ADDR 8'h00
`define OFS_INSTR_WORD 8'h04
`define OFS_RETURN_ADDR 8'h08
`define OFS_LOOP_COUNT 8'h0C
`define OFS_COND_FLAGS 8'h10
`define OFS_NEXT_ADDR 8'h14
`define OFS_STATUS 8'h18

`define RST_WORD 32'h0000_0000
`define INSTR_STEP 32'h0000_0004
`define LOW2_MASK 32'hFFFF_FFFC

`define OPC_REL_JUMP 6'h12
`define OPC_COND_JUMP 6'h10
`define OPC_EXTENDED 6'h13
`define XO_TO_RETURN 10'h010
`define XO_TO_COUNT 10'h210
`define XO_AND 10'h101
`define XO_OR 10'h1C1
`define XO_XOR 10'h0C1
`define XO_NAND 10'h0E1
`define XO_NOR 10'h021
`define XO_EQV 10'h121
`define XO_ANDC 10'h081
`define XO_ORC 10'h1A1
`define XO_FIELD_COPY 10'h000

`define ST_TAKEN 0
`define ST_LINKED 1
`define ST_INVALID 2
`define ST_UNKNOWN 3
`define ST_DECR 4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hw/branch_pkg.sv
// Types and helpers shared by the flow-control execution block.
// Assumes flag bit 0 is the most significant bit of the flag word.
package branch_pkg;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_EXEC = 2'h1,
        WR_RESP = 2'h3
    } wr_state_t;

    typedef enum logic [2:0] {
        OP_REL_JUMP = 3'h0,
        OP_COND_JUMP = 3'h1,
        OP_TO_RETURN = 3'h2,
        OP_TO_COUNT = 3'h3,
        OP_FLAG_LOGIC = 3'h4,
        OP_UNKNOWN = 3'h5
    } op_kind_t;

    // Flag numbering runs from the top bit down
    function automatic logic flag_at(input logic [31:0] flags,
                                     input logic [4:0] n);
        return flags[5'h1F - n];
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// File: hw/flag_logic_unit.sv
// Bitwise flag operations and field copy on the condition flag word.
// Assumes the caller decides whether the result is written back.
`timescale 1ns/10ps
`include "branch_params.svh"
module flag_logic_unit (
    input wire logic [31:0] flags_in,
    input wire logic [9:0] ext_op,
    input wire logic [4:0] dest_flag_bit,
    input wire logic [4:0] first_src_flag_bit,
    input wire logic [4:0] second_src_flag_bit,
    input wire logic [2:0] dest_flag_field,
    input wire logic [2:0] src_flag_field,
    output logic [31:0] flags_out,
    output logic known
);
    logic a;
    logic b;
    logic res;
    logic is_copy;

    assign a = branch_pkg::flag_at(flags_in, first_src_flag_bit);
    assign b = branch_pkg::flag_at(flags_in, second_src_flag_bit);
    assign is_copy = ext_op == `XO_FIELD_COPY;

    assign res = (ext_op == `XO_AND) ? (a & b) :
                 (ext_op == `XO_OR) ? (a | b) :
                 (ext_op == `XO_XOR) ? (a ^ b) :
                 (ext_op == `XO_NAND) ? ~(a & b) :
                 (ext_op == `XO_NOR) ? ~(a | b) :
                 (ext_op == `XO_EQV) ? ~(a ^ b) :
                 (ext_op == `XO_ANDC) ? (a & ~b) :
                 (a | ~b);

    assign known = is_copy || ext_op == `XO_AND || ext_op == `XO_OR ||
                   ext_op == `XO_XOR || ext_op == `XO_NAND ||
                   ext_op == `XO_NOR || ext_op == `XO_EQV ||
                   ext_op == `XO_ANDC || ext_op == `XO_ORC;

    genvar j;
    generate
        for (j = 0; j < 32; j++) begin : g_bit
            localparam logic [4:0] NUM = 5'(31 - j);
            localparam logic [2:0] FLD = 3'((31 - j) / 4);
            localparam logic [1:0] OFF = 2'((31 - j) % 4);
            logic copy_bit;
            assign copy_bit = branch_pkg::flag_at(flags_in,
                                                  {src_flag_field, OFF});
            // Only the addressed field or bit changes
            assign flags_out[j] = is_copy ?
                ((dest_flag_field == FLD) ? copy_bit : flags_in[j]) :
                ((dest_flag_bit == NUM) ? res : flags_in[j]);
        end
    endgenerate
endmodule

// File: hw/branch_and_cond_reg_logic.sv
// Flow-control execution block: branches, link, loop count, flag logic.
// Assumes an AXI4-Lite master, one write and one read in flight at most.
`timescale 1ns/10ps
`include "branch_params.svh"
module branch_and_cond_reg_logic (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic redirect_valid,
    output logic [31:0] redirect_addr
);
    branch_pkg::wr_state_t state_ff;
    branch_pkg::wr_state_t nxt_state;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic aw_have_ff;
    logic w_have_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [31:0] instr_addr_ff;
    logic [31:0] instr_word_ff;
    logic [31:0] return_address_reg_ff;
    logic [31:0] loop_count_reg_ff;
    logic [31:0] condition_flags_reg_ff;
    logic [31:0] next_addr_ff;
    logic [4:0] status_ff;
    logic redirect_valid_ff;
    logic [31:0] redirect_addr_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign redirect_valid = redirect_valid_ff;
    assign redirect_addr = redirect_addr_ff;

    // Write channel handshakes; address and data may arrive in any order
    logic aw_hs;
    logic w_hs;
    logic both_in;
    logic nxt_aw_have;
    logic nxt_w_have;
    assign aw_hs = awvalid && awready_ff;
    assign w_hs = wvalid && wready_ff;
    assign both_in = (aw_have_ff || aw_hs) && (w_have_ff || w_hs);
    assign nxt_aw_have = state_ff == branch_pkg::WR_IDLE && !both_in &&
                         (aw_have_ff || aw_hs);
    assign nxt_w_have = state_ff == branch_pkg::WR_IDLE && !both_in &&
                        (w_have_ff || w_hs);

    always_comb begin
        case (state_ff)
            branch_pkg::WR_IDLE: begin
                nxt_state = both_in ? branch_pkg::WR_EXEC :
                                      branch_pkg::WR_IDLE;
            end
            branch_pkg::WR_EXEC: begin
                nxt_state = branch_pkg::WR_RESP;
            end
            branch_pkg::WR_RESP: begin
                nxt_state = bready ? branch_pkg::WR_IDLE : branch_pkg::WR_RESP;
            end
            default: begin
                nxt_state = branch_pkg::WR_IDLE;
            end
        endcase
    end

    // Write address decode
    logic [7:0] wr_ofs;
    logic exec_now;
    logic sel_addr;
    logic sel_instr;
    logic sel_return;
    logic sel_count;
    logic sel_flags;
    logic exec_instr;
    assign wr_ofs = {awaddr_ff[7:2], 2'h0};
    assign exec_now = state_ff == branch_pkg::WR_EXEC;
    assign sel_addr = wr_ofs == `OFS_INSTR_ADDR;
    assign sel_instr = wr_ofs == `OFS_INSTR_WORD;
    assign sel_return = wr_ofs == `OFS_RETURN_ADDR;
    assign sel_count = wr_ofs == `OFS_LOOP_COUNT;
    assign sel_flags = wr_ofs == `OFS_COND_FLAGS;
    assign exec_instr = exec_now && sel_instr;

    // Instruction fields; the written word is the instruction
    logic [31:0] ins;
    logic [5:0] opc;
    logic [9:0] ext_op;
    logic [4:0] branch_options;
    logic [4:0] condition_bit_select;
    logic abs_form;
    logic link_update_option;
    branch_pkg::op_kind_t kind;
    assign ins = wdata_ff;
    assign opc = ins[31:26];
    assign ext_op = ins[10:1];
    assign branch_options = ins[25:21];
    assign condition_bit_select = ins[20:16];
    assign abs_form = ins[1];
    assign link_update_option = ins[0];

    logic logic_known;
    logic [31:0] flags_result;
    assign kind = (opc == `OPC_REL_JUMP) ? branch_pkg::OP_REL_JUMP :
        (opc == `OPC_COND_JUMP) ? branch_pkg::OP_COND_JUMP :
        (opc != `OPC_EXTENDED) ? branch_pkg::OP_UNKNOWN :
        (ext_op == `XO_TO_RETURN) ? branch_pkg::OP_TO_RETURN :
        (ext_op == `XO_TO_COUNT) ? branch_pkg::OP_TO_COUNT :
        logic_known ? branch_pkg::OP_FLAG_LOGIC : branch_pkg::OP_UNKNOWN;

    flag_logic_unit u_flags (
        .flags_in(condition_flags_reg_ff),
        .ext_op(ext_op),
        .dest_flag_bit(ins[25:21]),
        .first_src_flag_bit(ins[20:16]),
        .second_src_flag_bit(ins[15:11]),
        .dest_flag_field(ins[25:23]),
        .src_flag_field(ins[20:18]),
        .flags_out(flags_result),
        .known(logic_known)
    );

    // Branch options: ignore-condition, want-true, no-decrement, want-zero
    logic ignore_cond;
    logic want_true;
    logic no_decr;
    logic want_zero;
    logic flag_bit;
    logic [31:0] count_dec;
    logic count_ok;
    logic cond_ok;
    assign ignore_cond = branch_options[4];
    assign want_true = branch_options[3];
    assign no_decr = branch_options[2];
    assign want_zero = branch_options[1];
    assign flag_bit = branch_pkg::flag_at(condition_flags_reg_ff,
                                          condition_bit_select);
    assign count_dec = loop_count_reg_ff - `INSTR_STEP / `INSTR_STEP;
    assign count_ok = no_decr ||
                      ((count_dec == `RST_WORD) == want_zero);
    assign cond_ok = ignore_cond || (flag_bit == want_true);

    // Targets
    logic [31:0] rel_disp;
    logic [31:0] cond_disp;
    logic [31:0] jump_disp;
    logic [31:0] jump_base;
    logic [31:0] seq_addr;
    logic [31:0] ret_target;
    logic [31:0] count_target;
    logic [31:0] target;
    logic taken;
    assign rel_disp = {{6{ins[25]}}, ins[25:2], 2'h0};
    assign cond_disp = {{16{ins[15]}}, ins[15:2], 2'h0};
    assign jump_disp = (kind == branch_pkg::OP_REL_JUMP) ?
                       rel_disp : cond_disp;
    assign jump_base = abs_form ? `RST_WORD : instr_addr_ff;
    assign seq_addr = instr_addr_ff + `INSTR_STEP;
    // Old return value feeds the target before any link write lands
    assign ret_target = return_address_reg_ff & `LOW2_MASK;
    assign count_target = loop_count_reg_ff & `LOW2_MASK;
    assign target =
        (kind == branch_pkg::OP_TO_RETURN) ? ret_target :
        (kind == branch_pkg::OP_TO_COUNT) ? count_target :
        jump_base + jump_disp;
    assign taken = (kind == branch_pkg::OP_REL_JUMP) ||
        ((kind == branch_pkg::OP_COND_JUMP ||
          kind == branch_pkg::OP_TO_RETURN) && cond_ok && count_ok) ||
        (kind == branch_pkg::OP_TO_COUNT && cond_ok && no_decr);

    logic is_branch;
    logic invalid;
    logic unknown;
    logic done_ok;
    logic do_link;
    logic do_decr;
    assign is_branch = kind != branch_pkg::OP_FLAG_LOGIC &&
                       kind != branch_pkg::OP_UNKNOWN;
    assign invalid = (kind == branch_pkg::OP_TO_COUNT && !no_decr) ||
        (kind == branch_pkg::OP_FLAG_LOGIC && link_update_option);
    assign unknown = kind == branch_pkg::OP_UNKNOWN;
    assign done_ok = !invalid && !unknown;
    // Link is written even when the branch falls through
    assign do_link = is_branch && link_update_option && done_ok;
    assign do_decr = (kind == branch_pkg::OP_COND_JUMP ||
                      kind == branch_pkg::OP_TO_RETURN) && !no_decr && done_ok;

    // Next register values
    logic [31:0] nxt_instr_addr;
    logic [31:0] nxt_return;
    logic [31:0] nxt_count;
    logic [31:0] nxt_flags;
    logic wr_bad;
    assign nxt_instr_addr = (exec_instr && done_ok) ?
            (taken ? target : seq_addr) :
        (exec_now && sel_addr) ?
            branch_pkg::merge_bytes(instr_addr_ff, wdata_ff, wstrb_ff) :
        instr_addr_ff;
    assign nxt_return = (exec_instr && do_link) ? seq_addr :
        (exec_now && sel_return) ?
            branch_pkg::merge_bytes(return_address_reg_ff, wdata_ff,
                                    wstrb_ff) :
        return_address_reg_ff;
    assign nxt_count = (exec_instr && do_decr) ? count_dec :
        (exec_now && sel_count) ?
            branch_pkg::merge_bytes(loop_count_reg_ff, wdata_ff, wstrb_ff) :
        loop_count_reg_ff;
    assign nxt_flags =
        (exec_instr && done_ok && kind == branch_pkg::OP_FLAG_LOGIC) ?
            flags_result :
        (exec_now && sel_flags) ?
            branch_pkg::merge_bytes(condition_flags_reg_ff, wdata_ff,
                                    wstrb_ff) :
        condition_flags_reg_ff;
    assign wr_bad = !(sel_addr || sel_instr || sel_return ||
                      sel_count || sel_flags);

    // Read decode
    logic ar_hs;
    logic nxt_rvalid;
    logic [7:0] rd_ofs;
    logic rd_hit;
    logic [31:0] rd_mux;
    assign ar_hs = arvalid && arready_ff;
    assign nxt_rvalid = ar_hs || (rvalid_ff && !rready);
    assign rd_ofs = {araddr[7:2], 2'h0};
    assign rd_mux =
        (rd_ofs == `OFS_INSTR_ADDR) ? instr_addr_ff :
        (rd_ofs == `OFS_INSTR_WORD) ? instr_word_ff :
        (rd_ofs == `OFS_RETURN_ADDR) ? return_address_reg_ff :
        (rd_ofs == `OFS_LOOP_COUNT) ? loop_count_reg_ff :
        (rd_ofs == `OFS_COND_FLAGS) ? condition_flags_reg_ff :
        (rd_ofs == `OFS_NEXT_ADDR) ? next_addr_ff :
        (rd_ofs == `OFS_STATUS) ? {27'h0, status_ff} : `RST_WORD;
    assign rd_hit = rd_ofs <= `OFS_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= branch_pkg::WR_IDLE;
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            aw_have_ff <= nxt_aw_have;
            w_have_ff <= nxt_w_have;
            awready_ff <= nxt_state == branch_pkg::WR_IDLE && !nxt_aw_have;
            wready_ff <= nxt_state == branch_pkg::WR_IDLE && !nxt_w_have;
            bvalid_ff <= nxt_state == branch_pkg::WR_RESP;
            arready_ff <= !nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Payload registers need no reset; they are only read after capture
    always_ff @(posedge aclk) begin
        awaddr_ff <= aw_hs ? awaddr : awaddr_ff;
        wdata_ff <= w_hs ? wdata : wdata_ff;
        wstrb_ff <= w_hs ? wstrb : wstrb_ff;
        rdata_ff <= ar_hs ? rd_mux : rdata_ff;
        rresp_ff <= ar_hs ? (rd_hit ? `RESP_OKAY : `RESP_SLVERR) : rresp_ff;
        bresp_ff <= exec_now ? (wr_bad ? `RESP_SLVERR : `RESP_OKAY) : bresp_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_addr_ff <= `RST_WORD;
            instr_word_ff <= `RST_WORD;
            return_address_reg_ff <= `RST_WORD;
            loop_count_reg_ff <= `RST_WORD;
            condition_flags_reg_ff <= `RST_WORD;
            next_addr_ff <= `RST_WORD;
            status_ff <= 5'h00;
            redirect_valid_ff <= 1'b0;
            redirect_addr_ff <= `RST_WORD;
        end else begin
            instr_addr_ff <= nxt_instr_addr;
            return_address_reg_ff <= nxt_return;
            loop_count_reg_ff <= nxt_count;
            condition_flags_reg_ff <= nxt_flags;
            redirect_valid_ff <= exec_instr && done_ok && taken;
            redirect_addr_ff <= exec_instr ? target : redirect_addr_ff;
            if (exec_instr) begin
                instr_word_ff <= ins;
                next_addr_ff <= nxt_instr_addr;
                status_ff <= {do_decr, unknown, invalid, do_link,
                              done_ok && taken};
            end
        end
    end

    property p_rel_target;
        exec_instr && kind == branch_pkg::OP_REL_JUMP && !abs_form |=>
            redirect_valid && redirect_addr ==
            $past(instr_addr_ff) + $past(rel_disp);
    endproperty
    a_rel_target: assert property (p_rel_target) else $error("rel");

    property p_abs_target;
        exec_instr && abs_form && taken &&
        (kind == branch_pkg::OP_REL_JUMP || kind == branch_pkg::OP_COND_JUMP)
            |=> redirect_addr == $past(jump_disp);
    endproperty
    a_abs_target: assert property (p_abs_target) else $error("abs");

    property p_link_write;
        exec_instr && is_branch && link_update_option && done_ok |=>
            return_address_reg_ff == $past(instr_addr_ff) + `INSTR_STEP;
    endproperty
    a_link_write: assert property (p_link_write) else $error("link");

    property p_cond_test;
        exec_instr && kind == branch_pkg::OP_COND_JUMP && !ignore_cond &&
        no_decr |=> redirect_valid == ($past(flag_bit) == $past(want_true));
    endproperty
    a_cond_test: assert property (p_cond_test) else $error("cond");

    property p_ret_target;
        exec_instr && kind == branch_pkg::OP_TO_RETURN && taken |=>
            redirect_valid &&
            redirect_addr == ($past(return_address_reg_ff) & `LOW2_MASK);
    endproperty
    a_ret_target: assert property (p_ret_target) else $error("ret");

    property p_ret_link;
        exec_instr && kind == branch_pkg::OP_TO_RETURN && taken &&
        link_update_option |=>
            redirect_addr == ($past(return_address_reg_ff) & `LOW2_MASK) &&
            return_address_reg_ff == $past(seq_addr);
    endproperty
    a_ret_link: assert property (p_ret_link) else $error("ret link");

    property p_cnt_target;
        exec_instr && kind == branch_pkg::OP_TO_COUNT && taken |=>
            redirect_valid &&
            redirect_addr == ($past(loop_count_reg_ff) & `LOW2_MASK);
    endproperty
    a_cnt_target: assert property (p_cnt_target) else $error("cnt");

    property p_cnt_invalid;
        exec_instr && kind == branch_pkg::OP_TO_COUNT && !no_decr |=>
            status_ff[`ST_INVALID] && !redirect_valid &&
            return_address_reg_ff == $past(return_address_reg_ff) ##1
            !redirect_valid;
    endproperty
    a_cnt_invalid: assert property (p_cnt_invalid) else $error("cnt");

    property p_logic_invalid;
        exec_instr && kind == branch_pkg::OP_FLAG_LOGIC && link_update_option
            |=> status_ff[`ST_INVALID] &&
            condition_flags_reg_ff == $past(condition_flags_reg_ff);
    endproperty
    a_logic_invalid: assert property (p_logic_invalid)
        else $error("lk form");

    property p_always;
        exec_instr && kind == branch_pkg::OP_COND_JUMP && ignore_cond &&
        no_decr |=> redirect_valid ##1 !redirect_valid;
    endproperty
    a_always: assert property (p_always) else $error("always");

    property p_link_untaken;
        exec_instr && do_link && !taken |=> !redirect_valid &&
            return_address_reg_ff == $past(seq_addr);
    endproperty
    a_link_untaken: assert property (p_link_untaken)
        else $error("lk untaken");
endmodule

// File: tb/branch_and_cond_reg_logic_bench.sv
// Bench for the flow-control block, driven over AXI4-Lite.
// Assumes the register map and status layout of the block's params.
`timescale 1ns/10ps
`include "branch_params.svh"
module branch_and_cond_reg_logic_bench;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, redirect_valid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, redirect_addr;
    logic [1:0] bresp, rresp;
    int bad_count, n_checks, cyc, redir_n;
    logic [31:0] redir_addr;
    logic [9:0] ops [8];
    logic [7:0] res;
    branch_and_cond_reg_logic branch_and_cond_reg_logic_i (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .redirect_valid(redirect_valid),
        .redirect_addr(redirect_addr));
    initial begin
        aclk = 0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awready && !ad) begin
                ad = 1;
                awvalid <= 0;
            end
            if (wready && !wd) begin
                wd = 1;
                wvalid <= 0;
            end
        end
        while (!bvalid) @(posedge aclk);
        bready <= 0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        @(posedge aclk);
        while (!arready) @(posedge aclk);
        arvalid <= 0;
        @(posedge aclk);
        while (!rvalid) @(posedge aclk);
        rready <= 0;
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard: whole sequence needs well under 3000 cycles
    always @(posedge aclk) begin
        cyc++;
        // Pulse lasts one cycle, so catch it at every edge
        if (redirect_valid === 1'b1) begin
            redir_n++;
            redir_addr = redirect_addr;
        end
        if (cyc == 5000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        ops = '{`XO_AND, `XO_OR, `XO_XOR, `XO_NAND, `XO_NOR, `XO_EQV,
                `XO_ANDC, `XO_ORC};
        res = 8'h0E; // Flag16=0 op flag0=1, AND result at bit 0
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        wr(`OFS_INSTR_ADDR, 32'h100, `RESP_OKAY);
        wr(`OFS_INSTR_WORD, {6'h12, 24'hFFFFF0, 2'b01}, `RESP_OKAY);
        rd(`OFS_INSTR_ADDR, 32'hC0, `RESP_OKAY);
        chk(redir_addr, 32'hC0);
        rd(`OFS_RETURN_ADDR, 32'h104, `RESP_OKAY);
        rd(`OFS_STATUS, 32'h3, `RESP_OKAY);
        wr(`OFS_INSTR_WORD, {6'h12, 24'h000100, 2'b10}, `RESP_OKAY);
        rd(`OFS_INSTR_ADDR, 32'h400, `RESP_OKAY);
        chk(redir_addr, 32'h400);
        // Low bits set on purpose to see them dropped
        wr(`OFS_RETURN_ADDR, 32'h203, `RESP_OKAY);
        wr(`OFS_INSTR_WORD, {6'h13, 15'h5000, `XO_TO_RETURN, 1'b1},
           `RESP_OKAY);
        rd(`OFS_INSTR_ADDR, 32'h200, `RESP_OKAY);
        rd(`OFS_RETURN_ADDR, 32'h404, `RESP_OKAY);
        wr(`OFS_LOOP_COUNT, 32'h33, `RESP_OKAY);
        wr(`OFS_INSTR_WORD, {6'h13, 15'h5000, `XO_TO_COUNT, 1'b0},
           `RESP_OKAY);
        rd(`OFS_INSTR_ADDR, 32'h30, `RESP_OKAY);
        wr(`OFS_INSTR_WORD, {6'h13, 15'h4000, `XO_TO_COUNT, 1'b0},
           `RESP_OKAY);
        rd(`OFS_INSTR_ADDR, 32'h30, `RESP_OKAY);
        rd(`OFS_STATUS, 32'h4, `RESP_OKAY);
        chk(redir_n, 32'h4);
        wr(`OFS_COND_FLAGS, 32'hA000_0000, `RESP_OKAY);
        wr(`OFS_INSTR_WORD, {6'h10, 5'h0C, 5'd0, 14'h10, 2'b00}, `RESP_OKAY);
        rd(`OFS_INSTR_ADDR, 32'h70, `RESP_OKAY);
        wr(`OFS_INSTR_WORD, {6'h10, 5'h0C, 5'd1, 14'h10, 2'b01}, `RESP_OKAY);
        rd(`OFS_INSTR_ADDR, 32'h74, `RESP_OKAY);
        rd(`OFS_RETURN_ADDR, 32'h74, `RESP_OKAY);
        wr(`OFS_INSTR_WORD, {6'h10, 5'h04, 5'd1, 14'h10, 2'b00}, `RESP_OKAY);
        rd(`OFS_INSTR_ADDR, 32'hB4, `RESP_OKAY);
        // Decrement, branch on nonzero count, condition ignored
        wr(`OFS_INSTR_WORD, {6'h10, 5'h10, 5'h00, 14'h10, 2'h0}, `RESP_OKAY);
        rd(`OFS_INSTR_ADDR, 32'hF4, `RESP_OKAY);
        rd(`OFS_LOOP_COUNT, 32'h32, `RESP_OKAY);
        rd(`OFS_STATUS, 32'h11, `RESP_OKAY);
        wr(`OFS_INSTR_WORD, {6'h10, 5'h14, 5'h01, 14'h10, 2'h0}, `RESP_OKAY);
        rd(`OFS_INSTR_ADDR, 32'h134, `RESP_OKAY);
        chk(redir_addr, 32'h134);
        for (int i = 0; i < 8; i++) begin
            wr(`OFS_COND_FLAGS, 32'hA000_0000, `RESP_OKAY);
            wr(`OFS_INSTR_WORD, {6'h13, 15'h2200, ops[i], 1'b0}, `RESP_OKAY);
            rd(`OFS_COND_FLAGS, {8'hA0, res[i], 23'h0},
               `RESP_OKAY);
        end
        wr(`OFS_COND_FLAGS, 32'h1234_5678, `RESP_OKAY);
        // Destination field 3, source field 2
        wr(`OFS_INSTR_WORD, {6'h13, 15'h3100, `XO_FIELD_COPY, 1'b1},
           `RESP_OKAY);
        rd(`OFS_STATUS, 32'h4, `RESP_OKAY);
        rd(`OFS_COND_FLAGS, 32'h1234_5678, `RESP_OKAY);
        wr(`OFS_INSTR_WORD, {6'h13, 15'h3100, `XO_FIELD_COPY, 1'b0},
           `RESP_OKAY);
        rd(`OFS_COND_FLAGS, 32'h1233_5678, `RESP_OKAY);
        // Read-only and unmapped places answer with an error
        wr(`OFS_STATUS, 32'h0, `RESP_SLVERR);
        rd(8'h1C, 32'h0, `RESP_SLVERR);
        chk(redir_n, 32'h8);
        results();
    end
endmodule
